/* an_np_pkg.sv */
// Package with offsets, field layout, reset values and state of the next page register group
package an_np_pkg;

  // Avalon byte address width; printed offsets are register indices
  localparam int ADDR_W = 12;
  localparam int IDX_W = 10;
  localparam logic [IDX_W-1:0] IDX_TX_LOW = 10'h208;
  localparam logic [IDX_W-1:0] IDX_TX_MID = 10'h209;
  localparam logic [IDX_W-1:0] IDX_TX_HIGH = 10'h20A;
  localparam logic [IDX_W-1:0] IDX_RX_LOW = 10'h20B;
  localparam logic [IDX_W-1:0] IDX_RX_MID = 10'h20C;

  // Low word field positions
  localparam int MORE_BIT = 15;
  localparam int ACK_BIT = 14;
  localparam int TYPE_BIT = 13;
  localparam int COMPLY_BIT = 12;
  localparam int TOGGLE_BIT = 11;
  localparam int CODE_MSB = 10;

  // Reset values of the transmit words and received holds, and software-writable bits of the transmit low word
  localparam logic [15:0] TX_LOW_RESET = 16'h2001;
  localparam logic [15:0] TX_LOW_WMASK = 16'hB7FF;
  localparam logic [15:0] TX_MID_RESET = 16'h0000;
  localparam logic [15:0] TX_HIGH_RESET = 16'h0000;
  localparam logic [15:0] RX_HOLD_RESET = 16'h0000;

  // Message codes
  localparam logic [10:0] CODE_NULL = 11'h001;
  localparam logic [10:0] CODE_OUI_TAGGED = 11'h005;
  localparam logic [10:0] CODE_DEVICE_ID = 11'h006;

  // Page type encoding
  localparam logic TYPE_UNFORMATTED = 1'b0;
  localparam logic TYPE_MESSAGE = 1'b1;

  typedef struct packed {
    logic ack;
    logic [31:0] readdata;
    logic [15:0] tx_low;
    logic [15:0] tx_mid;
    logic [15:0] tx_high;
    logic load;
  } regs_s;

endpackage : an_np_pkg

/* word_hold.sv */
// Holding register that snapshots a live word on a capture strobe
`timescale 1ns/1ps
module word_hold #(
  parameter int WIDTH = 16,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic clear_i,
  input wire logic capture_i,
  // Data
  input wire logic [WIDTH-1:0] live_i,
  output logic [WIDTH-1:0] held_o
);

  logic [WIDTH-1:0] held;
  logic [WIDTH-1:0] next_held;

  always_comb begin
    next_held = held;
    if (clear_i) begin
      next_held = RESET_VAL;
    end else if (capture_i) begin
      next_held = live_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      held <= RESET_VAL;
    end else begin
      held <= next_held;
    end
  end

  assign held_o = held;

endmodule : word_hold

/* autoneg_next_page_regs.sv */
// Autonegotiation next page register group on an Avalon-MM slave
`timescale 1ns/1ps

// Behaviour
// [RULE1] Power-up or autoneg reset loads transmit low word with 0x2001, null message.
// [RULE2] Software writes middle and high transmit words before the low word.
// [RULE3] Transmit low bit 15 is a writable more-pages request flag.
// [RULE4] Transmit low bit 14 shows page acknowledge, read-only to software.
// [RULE5] Transmit low bit 13 writable page type, 1 message, 0 unformatted, resets 1.
// [RULE6] Transmit low bit 12 writable comply acknowledge.
// [RULE7] Transmit low toggle bit 11 always reads zero; arbitration drives real toggle.
// [RULE8] Transmit low bits 10:0 writable code; 1 null, 5 OUI tagged, 6 device id.
// [RULE9] Transmit middle word is 16-bit read-write, resets to zero.
// [RULE10] Transmit high word is 16-bit read-write, resets to zero.
// [RULE11] Reading received low word captures received middle and high words.
// [RULE12] Received middle word reads the value captured at last low-word read.
// [RULE13] Received low bit 13 reports partner page type, read-only.
// [RULE14] Received low bits 10:0 report partner code, read-only.
// [RULE15] Received low bit 14 reports partner acknowledge, read-only, resets zero.
// [RULE16] Received low bit 11 reports partner toggle, read-only, resets zero.
module autoneg_next_page_regs
  import an_np_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Arbitration side
  input wire logic an_reset_i,
  input wire logic tx_page_ack_i,
  input wire logic [47:0] rx_page_i,
  output logic [47:0] tx_page_o,
  output logic tx_page_load_o,
  output logic [15:0] rx_partner_page_high_o
);

  logic [1:0] rst_sync;
  logic rst_n;
  regs_s q;
  regs_s next_q;
  logic [IDX_W-1:0] idx;
  logic rd_start;
  logic wr_done;
  logic rx_capture;
  logic [15:0] rd_word;
  logic [15:0] rx_partner_page_mid;

  // Reset is released synchronously so no flop leaves reset on a different edge
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  assign idx = avs_address_i[ADDR_W-1:2];
  // Every access costs one wait cycle; read data is formed in the first cycle
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~q.ack;
  assign rd_start = avs_read_i & ~q.ack;
  assign wr_done = avs_write_i & q.ack;
  // Snapshot taken with the low word so all three words belong to one page
  assign rx_capture = rd_start && (idx == IDX_RX_LOW); // RULE11

  function automatic logic [15:0] merge_lanes(input logic [15:0] old_val,
                                              input logic [15:0] new_val,
                                              input logic [1:0] lanes);
    logic [15:0] res;
    res = old_val;
    if (lanes[0]) begin
      res[7:0] = new_val[7:0];
    end
    if (lanes[1]) begin
      res[15:8] = new_val[15:8];
    end
    return res;
  endfunction : merge_lanes

  always_comb begin
    rd_word = 16'h0000;
    unique case (idx)
      IDX_TX_LOW: begin
        rd_word = q.tx_low;
        rd_word[ACK_BIT] = tx_page_ack_i; // RULE4
        rd_word[TOGGLE_BIT] = 1'b0; // RULE7
      end
      IDX_TX_MID: rd_word = q.tx_mid; // RULE9
      IDX_TX_HIGH: rd_word = q.tx_high; // RULE10
      IDX_RX_LOW: rd_word = rx_page_i[15:0]; // RULE13 RULE14 RULE15 RULE16
      IDX_RX_MID: rd_word = rx_partner_page_mid; // RULE12
      default: rd_word = 16'h0000;
    endcase
  end

  always_comb begin
    next_q = q;
    next_q.load = 1'b0;
    next_q.ack = (avs_read_i | avs_write_i) & ~q.ack;
    if (rd_start) begin
      next_q.readdata = {16'h0000, rd_word};
    end
    if (wr_done) begin
      unique case (idx)
        IDX_TX_LOW: begin // RULE5 RULE6 RULE8
          // Unwritable bits stay at zero; ack and toggle come from arbitration
          next_q.tx_low = merge_lanes(q.tx_low, avs_writedata_i[15:0],
                                      avs_byteenable_i[1:0]) & TX_LOW_WMASK; // RULE3
          next_q.load = 1'b1;
        end
        IDX_TX_MID: begin
          next_q.tx_mid = merge_lanes(q.tx_mid, avs_writedata_i[15:0],
                                      avs_byteenable_i[1:0]); // RULE9
        end
        IDX_TX_HIGH: begin
          next_q.tx_high = merge_lanes(q.tx_high, avs_writedata_i[15:0],
                                       avs_byteenable_i[1:0]); // RULE10
        end
        default: begin
          next_q.load = 1'b0;
        end
      endcase
    end
    // Autoneg reset overrides a write landing on the same edge
    if (an_reset_i) begin
      next_q.tx_low = TX_LOW_RESET; // RULE1
      next_q.tx_mid = TX_MID_RESET;
      next_q.tx_high = TX_HIGH_RESET;
      next_q.load = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      q.ack <= 1'b0;
      q.readdata <= 32'h0000_0000;
      q.tx_low <= TX_LOW_RESET; // RULE1
      q.tx_mid <= TX_MID_RESET;
      q.tx_high <= TX_HIGH_RESET;
      q.load <= 1'b0;
    end else begin
      q <= next_q;
    end
  end

  word_hold #(
    .WIDTH(16),
    .RESET_VAL(RX_HOLD_RESET)
  ) hold_mid (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .clear_i(an_reset_i),
    .capture_i(rx_capture),
    .live_i(rx_page_i[31:16]),
    .held_o(rx_partner_page_mid)
  );

  word_hold #(
    .WIDTH(16),
    .RESET_VAL(RX_HOLD_RESET)
  ) hold_high (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .clear_i(an_reset_i),
    .capture_i(rx_capture),
    .live_i(rx_page_i[47:32]),
    .held_o(rx_partner_page_high_o)
  );

  assign avs_readdata_o = q.readdata;
  // Toggle position left at zero; the arbitration logic inserts its own
  assign tx_page_o = {q.tx_high, q.tx_mid, q.tx_low}; // RULE7
  assign tx_page_load_o = q.load;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n);

  logic low_wr_ok;
  assign low_wr_ok = wr_done && (idx == IDX_TX_LOW) && !an_reset_i;

  reset_default_a: assert property ( // RULE1
    an_reset_i |=> (q.tx_low == TX_LOW_RESET) && (tx_page_o[10:0] == CODE_NULL)
                   && (tx_page_o[TYPE_BIT] == TYPE_MESSAGE))
    else $error("autoneg reset did not restore transmit low default");

  more_flag_a: assert property ( // RULE3
    low_wr_ok && avs_byteenable_i[1] |=>
      tx_page_o[MORE_BIT] == $past(avs_writedata_i[MORE_BIT]))
    else $error("more-pages flag not written");

  ack_readonly_a: assert property ( // RULE4
    rd_start && (idx == IDX_TX_LOW) |=>
      (avs_readdata_o[ACK_BIT] == $past(tx_page_ack_i)) && !tx_page_o[ACK_BIT])
    else $error("acknowledge bit not read-only");

  page_type_a: assert property ( // RULE5
    low_wr_ok && avs_byteenable_i[1] |=>
      tx_page_o[TYPE_BIT] == $past(avs_writedata_i[TYPE_BIT]))
    else $error("page type bit not written");

  comply_bit_a: assert property ( // RULE6
    low_wr_ok && avs_byteenable_i[1] |=>
      tx_page_o[COMPLY_BIT] == $past(avs_writedata_i[COMPLY_BIT]))
    else $error("comply acknowledge bit not written");

  toggle_zero_a: assert property ( // RULE7
    rd_start && (idx == IDX_TX_LOW) |=> !avs_readdata_o[TOGGLE_BIT] ##1 !tx_page_o[TOGGLE_BIT])
    else $error("toggle bit did not read zero");

  code_field_a: assert property ( // RULE8
    low_wr_ok && (avs_byteenable_i[1:0] == 2'b11) |=>
      tx_page_o[CODE_MSB:0] == $past(avs_writedata_i[CODE_MSB:0]) && tx_page_load_o)
    else $error("code field not written");

  mid_write_a: assert property ( // RULE9
    wr_done && (idx == IDX_TX_MID) && (avs_byteenable_i[1:0] == 2'b11) && !an_reset_i |=>
      tx_page_o[31:16] == $past(avs_writedata_i[15:0]))
    else $error("transmit middle word not written");

  high_write_a: assert property ( // RULE10
    wr_done && (idx == IDX_TX_HIGH) && (avs_byteenable_i[1:0] == 2'b11) && !an_reset_i |=>
      tx_page_o[47:32] == $past(avs_writedata_i[15:0]))
    else $error("transmit high word not written");

  capture_a: assert property ( // RULE11
    rx_capture && !an_reset_i |=> (rx_partner_page_mid == $past(rx_page_i[31:16]))
                                  && (rx_partner_page_high_o == $past(rx_page_i[47:32])))
    else $error("received words not captured on low read");

  mid_latched_a: assert property ( // RULE12
    rd_start && (idx == IDX_RX_MID) |=> avs_readdata_o[15:0] == $past(rx_partner_page_mid))
    else $error("received middle word not the latched value");

  rx_type_a: assert property ( // RULE13
    rd_start && (idx == IDX_RX_LOW) |=> avs_readdata_o[TYPE_BIT] == $past(rx_page_i[TYPE_BIT]))
    else $error("partner page type wrong");

  rx_code_a: assert property ( // RULE14
    rd_start && (idx == IDX_RX_LOW) |=>
      avs_readdata_o[CODE_MSB:0] == $past(rx_page_i[CODE_MSB:0]))
    else $error("partner code wrong");

  rx_ack_a: assert property ( // RULE15
    rd_start && (idx == IDX_RX_LOW) |=> avs_readdata_o[ACK_BIT] == $past(rx_page_i[ACK_BIT]))
    else $error("partner acknowledge wrong");

  rx_toggle_a: assert property ( // RULE16
    rd_start && (idx == IDX_RX_LOW) |=>
      avs_readdata_o[TOGGLE_BIT] == $past(rx_page_i[TOGGLE_BIT]))
    else $error("partner toggle wrong");

  bus_answer_a: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("waitrequest held longer than one cycle");

  // Transmit page may only move on a completed write or an autoneg reset
  tx_hold_a: assert property ( // RULE9
    !wr_done && !an_reset_i |=> $stable(tx_page_o))
    else $error("transmit page changed without a write");

  ack_not_stored_a: assert property ( // RULE4
    low_wr_ok |=> !tx_page_o[ACK_BIT] && !tx_page_o[TOGGLE_BIT])
    else $error("read-only bit stored in transmit page");

  ro_write_a: assert property ( // RULE12
    wr_done && (idx >= IDX_RX_LOW) && !an_reset_i |=>
      $stable(tx_page_o) && $stable(rx_partner_page_mid))
    else $error("write to read-only place changed state");

  hold_stable_a: assert property ( // RULE11
    !rx_capture && !an_reset_i |=>
      $stable(rx_partner_page_mid) && $stable(rx_partner_page_high_o))
    else $error("received hold changed without a low-word read");

  rx_hold_clear_a: assert property ( // RULE12
    an_reset_i |=> (rx_partner_page_mid == RX_HOLD_RESET)
                   && (rx_partner_page_high_o == RX_HOLD_RESET))
    else $error("received holds not cleared by autoneg reset");

  readdata_hold_a: assert property (
    !rd_start |=> $stable(avs_readdata_o))
    else $error("read data changed without a read");

  unmapped_read_a: assert property (
    rd_start && ((idx < IDX_TX_LOW) || (idx > IDX_RX_MID)) |=>
      avs_readdata_o == 32'h0000_0000)
    else $error("unmapped read returned nonzero data");

  load_pulse_a: assert property (
    low_wr_ok |=> tx_page_load_o ##1 !tx_page_load_o)
    else $error("page load not a single pulse");

  low_write_c: cover property (low_wr_ok && tx_page_o[MORE_BIT] == 1'b0);
  rx_low_then_mid_c: cover property (rx_capture ##[2:8] (rd_start && idx == IDX_RX_MID));
  an_reset_c: cover property (an_reset_i ##1 tx_page_o[15:0] == TX_LOW_RESET);
  page_order_c: cover property ((wr_done && idx == IDX_TX_HIGH) ##[1:8] low_wr_ok);
  ack_read_c: cover property (rd_start && idx == IDX_TX_LOW && tx_page_ack_i);

endmodule : autoneg_next_page_regs

/* link_partner_model.sv */
// Behavioural remote link partner answering each loaded next page
`timescale 1ns/1ps
module link_partner_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Bench control
  input wire logic slow_i,
  input wire logic [47:0] next_page_i,
  // Device side
  input wire logic an_reset_i,
  input wire logic tx_page_load_i,
  output logic tx_page_ack_o,
  output logic [47:0] rx_page_o
);
  logic [3:0] wait_cnt;
  logic busy;

  // Slow mode stretches the answer so reads can land mid exchange
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wait_cnt <= 4'h0;
      busy <= 1'b0;
      tx_page_ack_o <= 1'b0;
      rx_page_o <= 48'h0;
    end else if (an_reset_i) begin
      busy <= 1'b0;
      tx_page_ack_o <= 1'b0;
    end else if (tx_page_load_i) begin
      busy <= 1'b1;
      tx_page_ack_o <= 1'b0;
      wait_cnt <= slow_i ? 4'h9 : 4'h1;
    end else if (busy) begin
      if (wait_cnt == 4'h0) begin
        busy <= 1'b0;
        tx_page_ack_o <= 1'b1;
        rx_page_o <= next_page_i;
      end else begin
        wait_cnt <= wait_cnt - 4'h1;
      end
    end
  end
endmodule : link_partner_model

/* testbench.sv */
// Self-checking bench for the next page register group
`timescale 1ns/1ps
module testbench;
  import an_np_pkg::*;
  logic clk_i, nrst_i, avs_read_i, avs_write_i, avs_waitrequest_o, an_reset_i, slow;
  logic [ADDR_W-1:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic [3:0] avs_byteenable_i;
  logic tx_page_ack_i, tx_page_load_o;
  logic [47:0] rx_page_i, tx_page_o, next_page;
  logic [15:0] rx_partner_page_high_o, exp_low, exp_mid, exp_high, rd;
  logic [31:0] snap;
  logic [10:0] codes [3];
  integer seed, errors, n_tests, cycles;

  autoneg_next_page_regs autoneg_next_page_regs_i (.clk_i(clk_i), .nrst_i(nrst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .an_reset_i(an_reset_i), .tx_page_ack_i(tx_page_ack_i), .rx_page_i(rx_page_i),
    .tx_page_o(tx_page_o), .tx_page_load_o(tx_page_load_o),
    .rx_partner_page_high_o(rx_partner_page_high_o));

  link_partner_model link_partner_model_i (.clk_i(clk_i), .nrst_i(nrst_i), .slow_i(slow),
    .next_page_i(next_page), .an_reset_i(an_reset_i), .tx_page_load_i(tx_page_load_o),
    .tx_page_ack_o(tx_page_ack_i), .rx_page_o(rx_page_i));

  always #12.5 clk_i = ~clk_i;

  task finish_test();
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      finish_test();
    end
  end

  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  function automatic logic [15:0] rnd();
    logic [31:0] r;
    r = $random(seed);
    return r[15:0];
  endfunction : rnd

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                        input logic [3:0] be);
    logic [15:0] m;
    m = {{8{be[1]}}, {8{be[0]}}} & TX_LOW_WMASK;
    return (old & ~m) | (wd & m);
  endfunction : merge

  // Request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [IDX_W-1:0] idx, input logic [15:0] wd,
                     input logic [3:0] be, output logic [15:0] rdata);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i <= {idx, 2'b00};
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_writedata_i <= {16'h0000, wd};
    avs_byteenable_i <= be;
    do begin
      @(posedge clk_i);
      n = n + 1;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (n == 50) errors = errors + 1;
    rdata = avs_readdata_o[15:0];
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : bus

  task automatic rchk(input logic [IDX_W-1:0] idx, input logic [15:0] exp);
    logic [15:0] r;
    bus(1'b0, idx, 16'h0000, 4'hF, r);
    check({32'h0, r}, {32'h0, exp});
  endtask : rchk

  task automatic send(input logic [15:0] low, input logic [3:0] be);
    logic [47:0] page;
    int n;
    page = {rnd(), rnd(), rnd()};
    next_page <= page;
    slow <= page[0];
    exp_mid = rnd();
    exp_high = rnd();
    bus(1'b1, IDX_TX_MID, exp_mid, 4'hF, rd);
    bus(1'b1, IDX_TX_HIGH, exp_high, 4'hF, rd);
    bus(1'b1, IDX_TX_LOW, low, be, rd);
    exp_low = merge(exp_low, low, be);
    @(negedge clk_i);
    check({47'h0, tx_page_load_o}, 48'h1);
    check(tx_page_o, {exp_high, exp_mid, exp_low});
    n = 0;
    while (!(rx_page_i === page && tx_page_ack_i === 1'b1) && n < 40) begin
      @(negedge clk_i);
      n = n + 1;
    end
    if (n == 40) errors = errors + 1;
    rchk(IDX_TX_LOW, exp_low | 16'h4000);
    rchk(IDX_TX_MID, exp_mid);
    rchk(IDX_TX_HIGH, exp_high);
    rchk(IDX_RX_MID, snap[15:0]);
    check({32'h0, rx_partner_page_high_o}, {32'h0, snap[31:16]});
    rchk(IDX_RX_LOW, page[15:0]);
    snap = page[47:16];
    rchk(IDX_RX_MID, snap[15:0]);
    check({32'h0, rx_partner_page_high_o}, {32'h0, snap[31:16]});
  endtask : send

  task automatic reset_checks();
    check(tx_page_o, {32'h0, TX_LOW_RESET});
    rchk(IDX_TX_LOW, 16'h2001);
    rchk(IDX_TX_MID, 16'h0000);
    rchk(IDX_TX_HIGH, 16'h0000);
    rchk(IDX_RX_MID, 16'h0000);
    exp_low = 16'h2001;
    snap = 32'h0;
  endtask : reset_checks

  initial begin
    seed = 32'hD025;
    {errors, n_tests, cycles} = '0;
    {clk_i, nrst_i, avs_read_i, avs_write_i, an_reset_i, slow} = '0;
    avs_address_i = '0;
    avs_writedata_i = '0;
    avs_byteenable_i = 4'hF;
    next_page = '0;
    codes = '{CODE_NULL, CODE_OUI_TAGGED, CODE_DEVICE_ID};
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    reset_checks();
    rchk(IDX_RX_LOW, 16'h0000);
    // Unmapped and read-only places keep their values
    bus(1'b1, 10'h3FF, 16'hFFFF, 4'hF, rd);
    rchk(10'h3FF, 16'h0000);
    bus(1'b1, IDX_RX_MID, 16'hFFFF, 4'hF, rd);
    rchk(IDX_RX_MID, 16'h0000);
    // Every code in both page types, with read-only bits written high
    for (int i = 0; i < 6; i++) begin
      send({i[0], 1'b1, (i < 3) ? TYPE_MESSAGE : TYPE_UNFORMATTED, i[1], 1'b1, codes[i % 3]},
           4'hF);
    end
    for (int i = 0; i < 20; i++) begin
      send(rnd(), 4'(rnd() % 4));
    end
    // Autonegotiation reset mid run restores defaults
    @(posedge clk_i);
    an_reset_i <= 1'b1;
    @(posedge clk_i);
    an_reset_i <= 1'b0;
    @(negedge clk_i);
    reset_checks();
    check({32'h0, rx_partner_page_high_o}, 48'h0);
    send({1'b0, 1'b0, TYPE_MESSAGE, 1'b0, 1'b0, CODE_NULL}, 4'hF);
    finish_test();
  end
endmodule : testbench
